// file: design/prl_pkg.sv
/*
 * Constants and types shared by the port ingress rate limiter.
 * Assumes a 125 MHz core clock and byte-wide registers on 32-bit APB.
 */
package prl_pkg;

    localparam int NPORT = 3;
    localparam int NQ = 4;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_P1_CTRL = 8'h15;
    localparam logic [7:0] IDX_P1_LIM0 = 8'h16;
    localparam logic [7:0] IDX_P1_LIM1 = 8'h17;
    localparam logic [7:0] IDX_P1_LIM2 = 8'h18;
    localparam logic [7:0] IDX_P1_LIM3 = 8'h19;
    localparam logic [7:0] IDX_P2_CTRL = 8'h25;
    localparam logic [7:0] IDX_P2_LIM0 = 8'h26;
    localparam logic [7:0] IDX_P2_LIM1 = 8'h27;
    localparam logic [7:0] IDX_P2_LIM2 = 8'h28;
    localparam logic [7:0] IDX_P2_LIM3 = 8'h29;
    localparam logic [7:0] IDX_P3_CTRL = 8'h35;
    localparam logic [7:0] IDX_P3_LIM0 = 8'h36;
    localparam logic [7:0] IDX_P3_LIM1 = 8'h37;
    localparam logic [7:0] IDX_P3_LIM2 = 8'h38;
    localparam logic [7:0] IDX_P3_LIM3 = 8'h39;
    localparam logic [7:0] IDX_CTRL [NPORT] =
        '{IDX_P1_CTRL, IDX_P2_CTRL, IDX_P3_CTRL};
    localparam logic [7:0] IDX_LIM [NPORT][NQ] = '{
        '{IDX_P1_LIM0, IDX_P1_LIM1, IDX_P1_LIM2, IDX_P1_LIM3},
        '{IDX_P2_LIM0, IDX_P2_LIM1, IDX_P2_LIM2, IDX_P2_LIM3},
        '{IDX_P3_LIM0, IDX_P3_LIM1, IDX_P3_LIM2, IDX_P3_LIM3}};

    // control and limit register fields
    localparam int MODE_LSB = 2;
    localparam int GAP_BIT = 1;
    localparam int PRE_BIT = 0;
    localparam int LIM_RSV_BIT = 7;
    localparam int LIM_Q_RW_RSV = 1;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [7:0] LIM_RESET = 8'h00;

    typedef enum logic [1:0] {
        MODE_ALL = 2'b00,
        MODE_BMF = 2'b01,
        MODE_BM = 2'b10,
        MODE_B = 2'b11
    } prl_mode_type;

    localparam logic [11:0] GAP_BYTES = 12'h00C;
    localparam logic [11:0] PRE_BYTES = 12'h008;

    // rate codes
    localparam logic [6:0] CODE_FULL_100 = 7'h64;
    localparam logic [6:0] CODE_FULL_10 = 7'h0A;
    localparam logic [6:0] CODE_SUB_FIRST = 7'h65;
    localparam logic [6:0] CODE_SUB_LAST = 7'h73;
    localparam logic [16:0] SUB_STEP_KBPS = 17'h00040;
    localparam logic [16:0] KBPS_PER_MBPS = 17'h003E8;

    // one byte of credit per ACC_THRESH kbps-cycles
    localparam int CLK_PERIOD_NS = 8;
    localparam int CLK_KHZ = 1000000 / CLK_PERIOD_NS;
    localparam logic [20:0] ACC_THRESH = 21'(CLK_KHZ * 8);
    localparam logic [11:0] BUCKET_DEPTH = 12'h800;

    typedef struct packed {
        logic [20:0] acc;
        logic [11:0] credit;
    } prl_bucket_state_type;

    typedef struct packed {
        logic [NPORT-1:0][3:0] ctrl;
        logic [NPORT-1:0][NQ-1:0][7:0] lim;
        logic [31:0] prdata;
        logic [NPORT-1:0] pass;
        logic [NPORT-1:0] drop;
    } prl_regs_type;

endpackage

// file: design/prl_bucket.sv
/*
 * One token bucket: earns byte credit at a programmed kbps rate and
 * spends it on admitted frames.
 * Assumes charge is only raised when enough is high.
 */
`timescale 1ns/100ps
`default_nettype none

module prl_bucket (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [16:0] rate_kbps,
    input wire logic unlimited,
    input wire logic charge,
    input wire logic [11:0] charge_len,
    output logic enough
);

    prl_pkg::prl_bucket_state_type st_reg;
    prl_pkg::prl_bucket_state_type st_next;
    logic [20:0] acc_sum;

    assign acc_sum = st_reg.acc + {4'h0, rate_kbps};
    assign enough = unlimited || (st_reg.credit >= charge_len);

    always_comb begin
        st_next = st_reg;
        if (acc_sum >= prl_pkg::ACC_THRESH) begin
            st_next.acc = acc_sum - prl_pkg::ACC_THRESH;
            if (st_reg.credit < prl_pkg::BUCKET_DEPTH) begin
                st_next.credit = st_reg.credit + 12'h001;
            end
        end else begin
            st_next.acc = acc_sum;
        end
        // saturate so an unlimited charge never wraps the credit
        if (charge) begin
            if (st_next.credit > charge_len) begin
                st_next.credit = st_next.credit - charge_len;
            end else begin
                st_next.credit = 12'h000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_CREDIT_CAPPED: assert property (
        st_reg.credit <= prl_pkg::BUCKET_DEPTH)
        else $error("bucket credit above depth");
    AST_CHARGE_SPENDS: assert property (
        charge && !unlimited && !(acc_sum >= prl_pkg::ACC_THRESH)
        |=> st_reg.credit == $past(st_reg.credit) - $past(charge_len))
        else $error("charge did not spend credit");

endmodule
`default_nettype wire

// file: design/prl_top.sv
/*
 * Per-port ingress rate limiter: APB register file and frame policing
 * for three ports with four priority buckets each.
 * Assumes the receive MAC presents one frame descriptor per cycle per
 * port on the core clock, with length, priority and class flags.
 */
`timescale 1ns/100ps
`default_nettype none

module prl_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] link_fast,
    input wire logic [2:0] frm_valid,
    input wire logic [2:0][10:0] frm_len,
    input wire logic [2:0][1:0] frm_prio,
    input wire logic [2:0] frm_bcast,
    input wire logic [2:0] frm_mcast,
    input wire logic [2:0] frm_flood,
    output logic [2:0] frm_pass,
    output logic [2:0] frm_drop
);

    localparam int NP = prl_pkg::NPORT;
    localparam int NQ = prl_pkg::NQ;

    prl_pkg::prl_regs_type r_reg;
    prl_pkg::prl_regs_type r_next;

    logic [7:0] idx;
    logic addr_ok;
    logic hit;
    logic [31:0] rd_val;
    logic wr_en;
    logic [NP-1:0] in_class;
    logic [NP-1:0][11:0] cnt_len;
    logic [NP-1:0] sel_enough;
    logic [NP-1:0][NQ-1:0] charge;
    logic [NP-1:0][NQ-1:0] enough;
    logic [NP-1:0][NQ-1:0] unl;
    logic [NP-1:0][NQ-1:0][16:0] kbps;

    // rate code to kbps; zero when the code means no limiting
    function automatic logic [16:0] code_kbps(input logic [6:0] code,
                                              input logic fast);
        logic [6:0] full;
        full = fast ? prl_pkg::CODE_FULL_100 : prl_pkg::CODE_FULL_10;
        code_kbps = 17'h00000;
        if (code >= prl_pkg::CODE_SUB_FIRST &&
            code <= prl_pkg::CODE_SUB_LAST) begin
            code_kbps = 17'(code - prl_pkg::CODE_FULL_100) *
                        prl_pkg::SUB_STEP_KBPS;
        end else if (code != 7'h00 && code < full) begin
            code_kbps = 17'(code) * prl_pkg::KBPS_PER_MBPS;
        end
    endfunction

    assign idx = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign wr_en = psel && penable && pwrite && hit && pstrb[0];
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = r_reg.prdata;
    assign frm_pass = r_reg.pass;
    assign frm_drop = r_reg.drop;

    // read mux and decode; bits above the byte read as zero
    always_comb begin
        hit = 1'b0;
        rd_val = 32'h0000_0000;
        for (int p = 0; p < NP; p++) begin
            if (addr_ok && idx == prl_pkg::IDX_CTRL[p]) begin
                hit = 1'b1;
                rd_val[3:0] = r_reg.ctrl[p];
            end
            for (int q = 0; q < NQ; q++) begin
                if (addr_ok && idx == prl_pkg::IDX_LIM[p][q]) begin
                    hit = 1'b1;
                    rd_val[7:0] = r_reg.lim[p][q];
                end
            end
        end
    end

    // frame classification and counted length per port
    always_comb begin
        in_class = '0;
        cnt_len = '0;
        sel_enough = '0;
        charge = '0;
        for (int p = 0; p < NP; p++) begin
            case (prl_pkg::prl_mode_type'(
                    r_reg.ctrl[p][prl_pkg::MODE_LSB +: 2]))
                prl_pkg::MODE_ALL: in_class[p] = 1'b1;
                prl_pkg::MODE_BMF: in_class[p] =
                    frm_bcast[p] | frm_mcast[p] | frm_flood[p];
                prl_pkg::MODE_BM: in_class[p] = frm_bcast[p] | frm_mcast[p];
                prl_pkg::MODE_B: in_class[p] = frm_bcast[p];
                default: in_class[p] = 1'b1;
            endcase
            cnt_len[p] = {1'b0, frm_len[p]};
            if (r_reg.ctrl[p][prl_pkg::GAP_BIT]) begin
                cnt_len[p] = cnt_len[p] + prl_pkg::GAP_BYTES;
            end
            if (r_reg.ctrl[p][prl_pkg::PRE_BIT]) begin
                cnt_len[p] = cnt_len[p] + prl_pkg::PRE_BYTES;
            end
            sel_enough[p] = enough[p][frm_prio[p]];
            if (frm_valid[p] && in_class[p] && sel_enough[p]) begin
                charge[p][frm_prio[p]] = 1'b1;
            end
        end
    end

    always_comb begin
        r_next = r_reg;
        r_next.pass = '0;
        r_next.drop = '0;
        // prdata loads in setup so it is stable through the access
        if (psel && !penable) begin
            r_next.prdata = rd_val;
        end
        if (wr_en) begin
            for (int p = 0; p < NP; p++) begin
                if (idx == prl_pkg::IDX_CTRL[p]) begin
                    r_next.ctrl[p] = pwdata[3:0];
                end
                for (int q = 0; q < NQ; q++) begin
                    if (idx == prl_pkg::IDX_LIM[p][q]) begin
                        r_next.lim[p][q][6:0] = pwdata[6:0];
                        // only the priority 1 reserved bit is stored
                        if (q == prl_pkg::LIM_Q_RW_RSV) begin
                            r_next.lim[p][q][prl_pkg::LIM_RSV_BIT] =
                                pwdata[prl_pkg::LIM_RSV_BIT];
                        end
                    end
                end
            end
        end
        for (int p = 0; p < NP; p++) begin
            // no frame store here, so an over-rate frame cannot wait
            // drop when the queue lacks credit
            if (frm_valid[p]) begin
                r_next.pass[p] = !in_class[p] || sel_enough[p];
                r_next.drop[p] = in_class[p] && !sel_enough[p];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    genvar gp, gq;
    generate
        for (gp = 0; gp < NP; gp++) begin : g_port
            for (gq = 0; gq < NQ; gq++) begin : g_q
                assign kbps[gp][gq] =
                    code_kbps(r_reg.lim[gp][gq][6:0], link_fast[gp]);
                assign unl[gp][gq] = (kbps[gp][gq] == 17'h00000);
                prl_bucket u_bucket (
                    .pclk(pclk),
                    .presetn(presetn),
                    .rate_kbps(kbps[gp][gq]),
                    .unlimited(unl[gp][gq]),
                    .charge(charge[gp][gq]),
                    .charge_len(cnt_len[gp]),
                    .enough(enough[gp][gq])
                );
            end
        end
    endgenerate

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    generate
        for (gp = 0; gp < NP; gp++) begin : g_chk
            AST_BCAST_ONLY_MODE: assert property (
                frm_valid[gp] && !frm_bcast[gp] &&
                r_reg.ctrl[gp][3:2] == 2'b11
                |=> frm_pass[gp] && !frm_drop[gp])
                else $error("non-broadcast frame limited in mode 11");
            AST_OUT_OF_CLASS_FREE: assert property (
                frm_valid[gp] && !in_class[gp] |-> charge[gp] == '0)
                else $error("out-of-class frame charged");
            AST_GAP_BYTES: assert property (
                r_reg.ctrl[gp][1:0] == 2'b10 |->
                cnt_len[gp] == {1'b0, frm_len[gp]} + 12'h00C)
                else $error("gap bytes not added");
            AST_PRE_BYTES: assert property (
                r_reg.ctrl[gp][1:0] == 2'b11 |->
                cnt_len[gp] == {1'b0, frm_len[gp]} + 12'h014)
                else $error("preamble and gap bytes wrong");
            AST_LIMIT_WRITE: assert property (
                wr_en && idx == prl_pkg::IDX_LIM[gp][3]
                |=> r_reg.lim[gp][3] == {1'b0, $past(pwdata[6:0])}
                ##1 $stable(r_reg.lim[gp][3]) || $past(wr_en))
                else $error("priority 3 limit write lost");
            AST_OVER_RATE_DROP: assert property (
                frm_valid[gp] && in_class[gp] && !sel_enough[gp]
                |=> frm_drop[gp] && !frm_pass[gp])
                else $error("over-rate frame not dropped");
            AST_RESET_ZERO: assert property (
                $rose(presetn) |-> r_reg.ctrl[gp] == 4'h0 &&
                r_reg.lim[gp] == '0)
                else $error("field not zero after reset");
            AST_CTRL_WRITE: assert property (
                wr_en && idx == prl_pkg::IDX_CTRL[gp]
                |=> r_reg.ctrl[gp] == $past(pwdata[3:0]))
                else $error("control write lost");
            AST_PRIO0_RSV_READ_ZERO: assert property (
                psel && penable && idx == prl_pkg::IDX_LIM[gp][0]
                |-> prdata[7] == 1'b0)
                else $error("read-only bit 7 of priority 0 not zero");
            AST_UNLIMITED_PASS: assert property (
                frm_valid[gp] && unl[gp][frm_prio[gp]]
                |=> frm_pass[gp] && !frm_drop[gp])
                else $error("unlimited queue dropped a frame");
            AST_ONE_ANSWER: assert property (
                !(frm_pass[gp] && frm_drop[gp]))
                else $error("frame both passed and dropped");
        end
    endgenerate

    // decode checks, repeated for every queue of every port
    generate
        for (gp = 0; gp < NP; gp++) begin : g_rate_chk
            for (gq = 0; gq < NQ; gq++) begin : g_rate_q
                AST_FAST_MBPS: assert property (
                    link_fast[gp] && r_reg.lim[gp][gq][6:0] == 7'h63
                    |-> kbps[gp][gq] == 17'h182B8 && !unl[gp][gq])
                    else $error("99 Mbps code decoded wrong");
                AST_SLOW_FULL: assert property (
                    !link_fast[gp] &&
                    r_reg.lim[gp][gq][6:0] inside {7'h00, 7'h0A}
                    |-> unl[gp][gq])
                    else $error("10M full-rate code limits traffic");
                AST_SUB_MEG: assert property (
                    r_reg.lim[gp][gq][6:0] == 7'h73
                    |-> kbps[gp][gq] == 17'h003C0)
                    else $error("sub-megabit code decoded wrong");
                AST_QUEUE_OWN_CHARGE: assert property (
                    charge[gp][gq] |-> frm_prio[gp] == 2'(gq))
                    else $error("bucket charged for another queue");
            end
        end
    endgenerate

    AST_PORT_ISOLATION: assert property (
        wr_en && idx == prl_pkg::IDX_P2_CTRL
        |=> $stable(r_reg.ctrl[0]) && $stable(r_reg.ctrl[2]) &&
        r_reg.ctrl[1] == $past(pwdata[3:0]))
        else $error("port 2 control write leaked");
    AST_PRDATA_UPPER_ZERO: assert property (
        prdata[31:8] == 24'h000000)
        else $error("read data above the byte not zero");
    AST_NO_STROBE_NO_WRITE: assert property (
        psel && penable && pwrite && !pstrb[0]
        |=> $stable(r_reg.ctrl) && $stable(r_reg.lim))
        else $error("write without byte strobe changed a register");

    COV_DROP: cover property (frm_drop[0]);
    COV_PASS_LIMITED: cover property (frm_pass[1] && !unl[1][0]);
    COV_SLVERR: cover property (pslverr);
    COV_SUB_RATE: cover property (kbps[2][3] == 17'h00040);
    COV_SLOW_DROP: cover property (!link_fast[0] && frm_drop[0]);

endmodule
`default_nettype wire

// file: verification/prl_mac_model.sv
/*
 * Receive-side frame source for the rate limiter: one descriptor per
 * call of send.
 * Assumes calls come from one process, one frame at a time.
 */
`timescale 1ns/100ps
`default_nettype none

module prl_mac_model (
    input wire logic pclk,
    output logic [2:0] frm_valid,
    output logic [2:0][10:0] frm_len,
    output logic [2:0][1:0] frm_prio,
    output logic [2:0] frm_bcast,
    output logic [2:0] frm_mcast,
    output logic [2:0] frm_flood
);
    initial begin
        frm_valid = '0;
        frm_len = '0;
        frm_prio = '0;
        frm_bcast = '0;
        frm_mcast = '0;
        frm_flood = '0;
    end

    // cls: 0 known unicast, 1 flooded unicast, 2 multicast, 3 broadcast
    task automatic send(input int p, input logic [10:0] len,
                        input logic [1:0] q, input int cls);
        @(posedge pclk);
        frm_valid[p] <= 1'b1;
        frm_len[p] <= len;
        frm_prio[p] <= q;
        frm_bcast[p] <= (cls == 3);
        frm_mcast[p] <= (cls == 2);
        frm_flood[p] <= (cls == 1);
        @(posedge pclk);
        frm_valid[p] <= 1'b0;
        // stale length and priority flip so a design reading them late cannot match
        frm_len[p] <= ~len;
        frm_prio[p] <= ~q;
    endtask
endmodule

`default_nettype wire

// file: verification/prl_top_tb.sv
/*
 * Self-checking bench for prl_top: register checks over APB and frame
 * policing through the receive-side model.
 * Assumes the zero-wait APB slave and one-cycle frame answer.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    miscompares++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end end

module prl_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic [2:0] link_fast = 3'h7;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [2:0] frm_valid, frm_bcast, frm_mcast, frm_flood;
    logic [2:0] frm_pass, frm_drop;
    logic [2:0][10:0] frm_len;
    logic [2:0][1:0] frm_prio;
    int miscompares = 0, n_checks = 0;
    logic [33:0] aq[$];
    logic [2:0] fq[$];
    logic [33:0] ae;
    logic [2:0] fe;
    logic [8:0] tbl [8] = '{9'h180, 9'h1E4, 9'h163, 9'h165,
                            9'h08A, 9'h080, 9'h009, 9'h073};

    always #4 pclk = ~pclk;

    prl_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_fast(link_fast), .frm_valid(frm_valid),
        .frm_len(frm_len), .frm_prio(frm_prio), .frm_bcast(frm_bcast),
        .frm_mcast(frm_mcast), .frm_flood(frm_flood),
        .frm_pass(frm_pass), .frm_drop(frm_drop));

    prl_mac_model mac (.pclk(pclk), .frm_valid(frm_valid),
        .frm_len(frm_len), .frm_prio(frm_prio), .frm_bcast(frm_bcast),
        .frm_mcast(frm_mcast), .frm_flood(frm_flood));

    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [7:0] wd, input logic [7:0] ed,
                       input logic ee);
        aq.push_back({~w, ee, 24'h000000, ed});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'($urandom), wd};
        @(posedge pclk);
        penable <= 1'b1;
        // no wait-state count is assumed; the watchdog ends a hung bus
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic frame(input int p, input logic [10:0] len,
                         input int q, input int cls, input logic ok);
        fq.push_back({ok, 2'(p)});
        mac.send(p, len, 2'(q), cls);
    endtask

    task automatic rst;
        // let the answer to the last frame show before reset clears it
        if (presetn) begin
            @(posedge pclk);
        end
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    task automatic tally_and_finish;
        `CHK("pending", 0, fq.size() + aq.size())
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // compare at the falling edge, where answers have settled
    always @(negedge pclk) begin
        if (psel && penable) `CHK("pready", 1'b1, pready)
        if (psel && penable && pready) begin
            ae = aq.pop_front();
            `CHK("pslverr", ae[32], pslverr)
            if (ae[33]) `CHK("prdata", ae[31:0], prdata)
        end
        for (int p = 0; p < 3; p++) begin
            if (frm_pass[p] | frm_drop[p]) begin
                fe = fq.pop_front();
                `CHK("frame port", fe[1:0], 2'(p))
                `CHK("pass drop", {fe[2], ~fe[2]}, {frm_pass[p], frm_drop[p]})
            end
        end
    end

    initial begin
        #(8 * 40000);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        logic [7:0] v;
        int p, q, xl;
        void'($urandom(32'hE620FE98));
        rst();
        for (p = 0; p < 3; p++) begin
            apb(0, prl_pkg::IDX_CTRL[p], 8'h00, 8'h00, 0);
            for (q = 0; q < 4; q++) begin
                apb(0, prl_pkg::IDX_LIM[p][q], 8'h00, 8'h00, 0);
            end
        end
        apb(0, 8'h1A, 8'h00, 8'h00, 1);
        apb(1, 8'h1A, 8'hFF, 8'h00, 1);
        // a write without its byte strobe must leave the register alone
        pstrb <= 4'h0;
        apb(1, prl_pkg::IDX_P1_CTRL, 8'h0F, 8'h00, 0);
        pstrb <= 4'hF;
        apb(0, prl_pkg::IDX_P1_CTRL, 8'h00, 8'h00, 0);
        for (p = 0; p < 3; p++) begin
            v = 8'($urandom);
            apb(1, prl_pkg::IDX_CTRL[p], v, 8'h00, 0);
            apb(0, prl_pkg::IDX_CTRL[p], 8'h00, {4'h0, v[3:0]}, 0);
            for (q = 0; q < 4; q++) begin
                // reserved bit 7 set only where it is read-only
                v = {q == 0, 7'($urandom)};
                apb(1, prl_pkg::IDX_LIM[p][q], v, 8'h00, 0);
                apb(0, prl_pkg::IDX_LIM[p][q], 8'h00, {1'b0, v[6:0]}, 0);
            end
        end
        for (int m = 0; m < 4; m++) begin
            rst();
            p = $urandom_range(2);
            q = $urandom_range(3);
            apb(1, prl_pkg::IDX_CTRL[p], {4'h0, 2'(m), 2'b00}, 8'h00, 0);
            apb(1, prl_pkg::IDX_LIM[p][q], 8'h63, 8'h00, 0);
            for (int c = 0; c < 4; c++) begin
                frame(p, 11'h040, q, c, c < m);
            end
            frame(p, 11'h040, (q + 1) % 4, 0, 1'b1);
        end
        for (int i = 0; i < 8; i++) begin
            rst();
            p = $urandom_range(2);
            q = $urandom_range(3);
            link_fast <= {3{tbl[i][8]}};
            apb(1, prl_pkg::IDX_LIM[p][q], {1'b0, tbl[i][6:0]}, 8'h00, 0);
            frame(p, 11'h040, q, 3, tbl[i][7]);
        end
        link_fast <= 3'h7;
        // 99 Mbps earns 198 bytes of credit over about 2000 cycles
        for (int f = 0; f < 4; f++) begin
            rst();
            p = $urandom_range(2);
            q = $urandom_range(3);
            apb(1, prl_pkg::IDX_CTRL[p], {6'h00, 2'(f)}, 8'h00, 0);
            apb(1, prl_pkg::IDX_LIM[p][q], 8'h63, 8'h00, 0);
            repeat (2000) @(posedge pclk);
            xl = 188 + ((f & 2) ? 12 : 0) + ((f & 1) ? 8 : 0);
            frame(p, 11'h0BC, q, 0, xl <= 198);
            frame(p, 11'h014, q, 0, xl > 198);
        end
        repeat (3) @(posedge pclk);
        tally_and_finish();
    end
endmodule

`default_nettype wire
